//--- hdl/rr_channel.sv
// one multiplexer channel: select, sync gating, counting, event
`timescale 1ns/1ps
module rr_channel (
  input wire logic CORE_CLK,
  input wire logic RST,
  input wire logic [31:0] CFG,
  input wire logic [rr_pkg::NUM_REQ-1:0] REQ_IN,
  input wire logic [rr_pkg::NUM_SYNC-1:0] SYNC_IN,
  input wire logic REQ_ACK,
  output logic REQ_OUT,
  output logic EVT_OUT,
  output logic OVR_PULSE
);
  logic [6:0] sel;
  logic [4:0] sync_sel;
  logic [4:0] fwd_cnt_max;
  logic [1:0] pol;
  logic sync_en;
  logic evt_en;
  logic sel_req;
  logic sync_lvl;
  logic sync_prev;
  logic sync_evt;
  logic served;
  logic last;
  logic [4:0] cnt;
  rr_pkg::rr_state_t state;

  // ---------------------------------------------------------------
  // field decode and selection
  // ---------------------------------------------------------------
  assign sel = CFG[rr_pkg::SEL_LSB +: rr_pkg::SEL_W];
  assign sync_sel = CFG[rr_pkg::SYNC_LSB +: rr_pkg::SYNC_W];
  assign fwd_cnt_max = CFG[rr_pkg::CNT_LSB +: rr_pkg::CNT_W];
  assign pol = CFG[rr_pkg::POL_LSB +: rr_pkg::POL_W];
  assign sync_en = CFG[rr_pkg::SYNC_EN_BIT];
  assign evt_en = CFG[rr_pkg::EVT_EN_BIT];
  assign sel_req = rr_pkg::rr_req_code_ok(sel) && REQ_IN[sel];
  assign sync_lvl = rr_pkg::rr_sync_code_ok(sync_sel) && SYNC_IN[sync_sel];

  // ---------------------------------------------------------------
  // edge detection
  // ---------------------------------------------------------------
  always_ff @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
      sync_prev <= 1'b0;
    end else begin
      sync_prev <= sync_lvl;
    end
  end

  always_comb begin
    case (pol)
      rr_pkg::POL_RISE: sync_evt = sync_lvl & ~sync_prev;
      rr_pkg::POL_FALL: sync_evt = ~sync_lvl & sync_prev;
      rr_pkg::POL_BOTH: sync_evt = sync_lvl ^ sync_prev;
      default: sync_evt = 1'b0;
    endcase
  end

  // ---------------------------------------------------------------
  // forwarding window
  // ---------------------------------------------------------------
  // without sync the gate stays open; a served request counts unless sync and events are both off
  assign REQ_OUT = sel_req && (!sync_en || state == rr_pkg::RR_FWD);
  assign served = REQ_OUT && REQ_ACK;
  assign last = served && (cnt == fwd_cnt_max);

  always_ff @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
      state <= rr_pkg::RR_WAIT;
    end else begin
      case (state)
        rr_pkg::RR_WAIT: begin
          if (sync_en && sync_evt) begin
            state <= rr_pkg::RR_FWD;
          end
        end
        rr_pkg::RR_FWD: begin
          if (!sync_en || last) begin
            state <= rr_pkg::RR_WAIT;
          end
        end
        default: state <= rr_pkg::RR_WAIT;
      endcase
    end
  end

  always_ff @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
      cnt <= 5'h00;
    end else if (!sync_en && !evt_en) begin
      cnt <= 5'h00;
    end else if (last) begin
      cnt <= 5'h00;
    end else if (served) begin
      cnt <= cnt + 5'h01;
    end else if (sync_en && sync_evt && state == rr_pkg::RR_WAIT) begin
      cnt <= 5'h00;
    end
  end

  // ---------------------------------------------------------------
  // output event and overrun
  // ---------------------------------------------------------------
  always_ff @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
      EVT_OUT <= 1'b0;
    end else begin
      EVT_OUT <= evt_en && last;
    end
  end

  // a sync edge inside an unfinished window is not queued, only flagged
  assign OVR_PULSE = sync_en && sync_evt && state == rr_pkg::RR_FWD &&
    !last;
endmodule // rr_channel

//--- hdl/rr_pkg.sv
// constants and field layout of the request router channel configuration
package rr_pkg;
  localparam int unsigned NUM_CH = 12;
  localparam int unsigned NUM_REQ = 80;
  localparam int unsigned NUM_SYNC = 32;
  localparam int unsigned ADDR_W = 12;
  // ---------------------------------------------------------------
  // register map
  // ---------------------------------------------------------------
  localparam logic [11:0] CFG_BASE = 12'h000;
  localparam logic [11:0] CFG_STRIDE = 12'h004;
  localparam logic [11:0] FLAGS_ADDR = 12'h080;
  localparam logic [11:0] CLEARS_ADDR = 12'h084;
  localparam logic [31:0] CFG_RESET = 32'h0000_0000;
  localparam logic [31:0] CFG_MASK = 32'h1fff_037f;
  // ---------------------------------------------------------------
  // configuration fields
  // ---------------------------------------------------------------
  localparam int unsigned SEL_LSB = 0;
  localparam int unsigned SEL_W = 7;
  localparam int unsigned IRQ_EN_BIT = 8;
  localparam int unsigned EVT_EN_BIT = 9;
  localparam int unsigned SYNC_EN_BIT = 16;
  localparam int unsigned POL_LSB = 17;
  localparam int unsigned POL_W = 2;
  localparam int unsigned CNT_LSB = 19;
  localparam int unsigned CNT_W = 5;
  localparam int unsigned SYNC_LSB = 24;
  localparam int unsigned SYNC_W = 5;
  // ---------------------------------------------------------------
  // code assignment of request, trigger and sync selects
  // ---------------------------------------------------------------
  localparam logic [6:0] REQ_CODE_MAX = 7'h4f;
  localparam logic [6:0] REQ_CODE_RSVD = 7'h07;
  localparam logic [4:0] EXT_LINE_MAX = 5'h0f;
  localparam logic [4:0] EVT_OUT_MAX = 5'h13;
  localparam logic [4:0] TIMER_OUT_CODE = 5'h16;
  localparam logic [1:0] POL_NONE = 2'h0;
  localparam logic [1:0] POL_RISE = 2'h1;
  localparam logic [1:0] POL_FALL = 2'h2;
  localparam logic [1:0] POL_BOTH = 2'h3;

  typedef enum logic [1:0] {
    RR_WAIT = 2'b01,
    RR_FWD = 2'b10
  } rr_state_t;

  // trigger and sync codes share one assignment
  function automatic logic rr_sync_code_ok(input logic [4:0] code);
    rr_sync_code_ok = (code <= EVT_OUT_MAX) || (code == TIMER_OUT_CODE);
  endfunction

  function automatic logic rr_req_code_ok(input logic [6:0] code);
    rr_req_code_ok = (code != 7'h00) && (code != REQ_CODE_RSVD) &&
      (code <= REQ_CODE_MAX);
  endfunction
endpackage

//--- hdl/rr_top.sv
// request router: channel configuration registers and twelve channels
`timescale 1ns/1ps
module rr_top #(
  parameter int unsigned CHANNELS = rr_pkg::NUM_CH
) (
  input wire logic CORE_CLK,
  input wire logic RST,
  input wire logic [rr_pkg::ADDR_W-1:0] REG_ADDR,
  input wire logic [31:0] REG_WDATA,
  input wire logic REG_WR,
  input wire logic REG_RD,
  output logic [31:0] REG_RDATA,
  input wire logic [rr_pkg::NUM_REQ-1:0] REQ_IN,
  input wire logic [rr_pkg::NUM_SYNC-1:0] SYNC_IN,
  input wire logic [CHANNELS-1:0] REQ_ACK,
  output logic [CHANNELS-1:0] REQ_OUT,
  output logic [CHANNELS-1:0] EVT_OUT,
  output logic SYNC_OVR_IRQ
);
  logic [31:0] cfg [CHANNELS];
  logic [CHANNELS-1:0] sync_overrun_flag;
  logic [CHANNELS-1:0] ovr_pulse;
  logic [CHANNELS-1:0] clr;
  logic [CHANNELS-1:0] irq_en;
  logic [31:0] next_rdata;

  // ---------------------------------------------------------------
  // address decode
  // ---------------------------------------------------------------
  // word index of a config register, or CHANNELS when outside the bank
  function automatic int unsigned cfg_index(
      input logic [rr_pkg::ADDR_W-1:0] a);
    cfg_index = CHANNELS;
    for (int unsigned i = 0; i < CHANNELS; i++) begin
      if (a == rr_pkg::CFG_BASE + 12'(i) * rr_pkg::CFG_STRIDE) begin
        cfg_index = i;
      end
    end
  endfunction

  // ---------------------------------------------------------------
  // configuration registers
  // ---------------------------------------------------------------
  // the forward count is taken as written; a change while enabled is
  // the caller's risk and simply retargets the running count
  always_ff @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
      for (int unsigned i = 0; i < CHANNELS; i++) begin
        cfg[i] <= rr_pkg::CFG_RESET;
      end
    end else if (REG_WR && cfg_index(REG_ADDR) < CHANNELS) begin
      cfg[cfg_index(REG_ADDR)] <= REG_WDATA & rr_pkg::CFG_MASK;
    end
  end

  // ---------------------------------------------------------------
  // channels
  // ---------------------------------------------------------------
  for (genvar c = 0; c < CHANNELS; c++) begin : g_ch
    rr_channel u_ch (
      .CORE_CLK(CORE_CLK),
      .RST(RST),
      .CFG(cfg[c]),
      .REQ_IN(REQ_IN),
      .SYNC_IN(SYNC_IN),
      .REQ_ACK(REQ_ACK[c]),
      .REQ_OUT(REQ_OUT[c]),
      .EVT_OUT(EVT_OUT[c]),
      .OVR_PULSE(ovr_pulse[c])
    );
    assign irq_en[c] = cfg[c][rr_pkg::IRQ_EN_BIT];
  end

  // ---------------------------------------------------------------
  // overrun flags
  // ---------------------------------------------------------------
  assign clr = (REG_WR && REG_ADDR == rr_pkg::CLEARS_ADDR) ?
    REG_WDATA[CHANNELS-1:0] : '0;

  // a new overrun in the clearing cycle survives the clear
  always_ff @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
      sync_overrun_flag <= '0;
    end else begin
      sync_overrun_flag <= (sync_overrun_flag & ~clr) | ovr_pulse;
    end
  end

  always_ff @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
      SYNC_OVR_IRQ <= 1'b0;
    end else begin
      SYNC_OVR_IRQ <= |(sync_overrun_flag & irq_en);
    end
  end

  // ---------------------------------------------------------------
  // read path
  // ---------------------------------------------------------------
  always_comb begin
    next_rdata = 32'h0000_0000;
    if (cfg_index(REG_ADDR) < CHANNELS) begin
      next_rdata = cfg[cfg_index(REG_ADDR)];
    end else if (REG_ADDR == rr_pkg::FLAGS_ADDR) begin
      next_rdata[CHANNELS-1:0] = sync_overrun_flag;
    end
  end

  // data is registered: it appears the cycle after the read strobe
  always_ff @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
      REG_RDATA <= 32'h0000_0000;
    end else if (REG_RD) begin
      REG_RDATA <= next_rdata;
    end
  end
endmodule // rr_top

//--- testbench/rr_chk.sv
// concurrent checks on the request router top ports
`timescale 1ns/1ps
module rr_chk #(
  parameter int unsigned CHANNELS = rr_pkg::NUM_CH
) (
  input wire logic CORE_CLK,
  input wire logic RST,
  input wire logic [rr_pkg::ADDR_W-1:0] REG_ADDR,
  input wire logic [31:0] REG_WDATA,
  input wire logic REG_WR,
  input wire logic REG_RD,
  input wire logic [31:0] REG_RDATA,
  input wire logic [rr_pkg::NUM_REQ-1:0] REQ_IN,
  input wire logic [rr_pkg::NUM_SYNC-1:0] SYNC_IN,
  input wire logic [CHANNELS-1:0] REQ_ACK,
  input wire logic [CHANNELS-1:0] REQ_OUT,
  input wire logic [CHANNELS-1:0] EVT_OUT,
  input wire logic SYNC_OVR_IRQ
);
  // one domain, so clock and reset are given once for all checks
  default clocking cb @(posedge CORE_CLK); endclocking
  default disable iff (RST);
  logic [CHANNELS-1:0] srv;
  assign srv = REQ_OUT & REQ_ACK;
  sequence cfg_wr_s;
    REG_WR && REG_ADDR == rr_pkg::CFG_BASE;
  endsequence
  sequence cfg_rd_s;
    REG_RD && REG_ADDR == rr_pkg::CFG_BASE;
  endsequence
  rdata_hold_a: assert property (!REG_RD |=> $stable(REG_RDATA))
    else $error("read data moved without a read");
  reset_quiet_a: assert property ($fell(RST) |->
    REQ_OUT == '0 && EVT_OUT == '0 && !SYNC_OVR_IRQ)
    else $error("outputs active after reset");
  cfg_readback_a: assert property (cfg_wr_s ##2 cfg_rd_s |=>
    REG_RDATA == ($past(REG_WDATA, 3) & rr_pkg::CFG_MASK))
    else $error("config readback wrong");
  cfg_reserved_a: assert property (REG_RD && REG_ADDR < 12'h030 |=>
    (REG_RDATA & ~rr_pkg::CFG_MASK) == 32'h0)
    else $error("reserved config bits set");
  unmapped_zero_a: assert property (REG_RD &&
    REG_ADDR inside {[12'h030:12'h07c]} |=> REG_RDATA == 32'h0)
    else $error("unmapped read not zero");
  flag_width_a: assert property (REG_RD &&
    REG_ADDR == rr_pkg::FLAGS_ADDR |=> REG_RDATA[31:12] == 20'h0)
    else $error("flag register upper bits set");
  clear_zero_a: assert property (REG_RD &&
    REG_ADDR == rr_pkg::CLEARS_ADDR |=> REG_RDATA == 32'h0)
    else $error("clear register read not zero");
  req_source_a: assert property (REQ_OUT != '0 |-> REQ_IN != '0)
    else $error("request forwarded without source");
  evt_cause_a: assert property ((EVT_OUT &
    ~($past(srv) | $past(srv, 2))) == '0)
    else $error("event without a served request");
endmodule // rr_chk
bind rr_top rr_chk #(.CHANNELS(CHANNELS)) rr_chk_i (
  .CORE_CLK(CORE_CLK), .RST(RST), .REG_ADDR(REG_ADDR),
  .REG_WDATA(REG_WDATA), .REG_WR(REG_WR), .REG_RD(REG_RD),
  .REG_RDATA(REG_RDATA), .REQ_IN(REQ_IN), .SYNC_IN(SYNC_IN),
  .REQ_ACK(REQ_ACK), .REQ_OUT(REQ_OUT), .EVT_OUT(EVT_OUT),
  .SYNC_OVR_IRQ(SYNC_OVR_IRQ));

//--- testbench/rr_dma_model.sv
// behavioural dma controller serving forwarded requests
`timescale 1ns/1ps
module rr_dma_model (
  input wire logic CORE_CLK,
  input wire logic RST,
  input wire logic [11:0] REQ_OUT,
  input wire logic STALL,
  output logic [11:0] REQ_ACK
);
  // one-cycle answer per request; stall stands for a busy controller
  always_ff @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
      REQ_ACK <= 12'h000;
    end else begin
      REQ_ACK <= REQ_OUT & ~REQ_ACK & {12{~STALL}};
    end
  end
endmodule // rr_dma_model

//--- testbench/rr_tb.sv
// self-checking bench for the request router
`timescale 1ns/1ps
module testbench;
  typedef struct packed {logic [6:0] sel; int line; logic out;} rr_row_t;
  typedef struct packed {logic [1:0] pol; logic [4:0] ss; int n;} rr_sync_t;
  rr_row_t rows [6] = '{'{7'h27, 39, 1'b1}, '{7'h4f, 79, 1'b1},
    '{7'h07, 7, 1'b0}, '{7'h50, 79, 1'b0}, '{7'h00, 0, 1'b0},
    '{7'h27, 40, 1'b0}};
  rr_sync_t ps [6] = '{'{2'h0, 5'h00, 0}, '{2'h1, 5'h00, 1},
    '{2'h2, 5'h0f, 1}, '{2'h3, 5'h11, 2}, '{2'h3, 5'h14, 0},
    '{2'h1, 5'h17, 0}};
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic stall = 1'b0;
  logic [11:0] addr = 12'h000;
  logic [31:0] wdata = 32'h0;
  logic [31:0] rdata, got;
  logic [79:0] req_in = '0;
  logic [31:0] sync_in = '0;
  logic [11:0] ack, req_out, evt_out;
  logic irq;
  int fail_count = 0;
  int samples_checked = 0;
  int cycles = 0;
  int evt1 = 0;
  int evt2 = 0;
  int srv1 = 0;
  int evt3 = 0;
  int srv3 = 0;
  rr_top rr_top_i (.CORE_CLK(clk), .RST(rst), .REG_ADDR(addr),
    .REG_WDATA(wdata), .REG_WR(wr), .REG_RD(rd), .REG_RDATA(rdata),
    .REQ_IN(req_in), .SYNC_IN(sync_in), .REQ_ACK(ack),
    .REQ_OUT(req_out), .EVT_OUT(evt_out), .SYNC_OVR_IRQ(irq));
  rr_dma_model rr_dma_model_i (.CORE_CLK(clk), .RST(rst),
    .REQ_OUT(req_out), .STALL(stall), .REQ_ACK(ack));
  always #5 clk = ~clk;
  task automatic conclude();
    $display("checks %0d mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    samples_checked++;
    if (s !== e) begin
      fail_count++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask
  // whole-word accesses only, one idle cycle after each
  task automatic wr_reg(input logic [11:0] a, input logic [31:0] d);
    addr = a;
    wdata = d;
    wr = 1'b1;
    @(negedge clk);
    wr = 1'b0;
    @(negedge clk);
  endtask
  task automatic rd_reg(input logic [11:0] a);
    addr = a;
    rd = 1'b1;
    @(negedge clk);
    rd = 1'b0;
    @(negedge clk);
    got = rdata;
  endtask
  task automatic pulse_sync(input int b);
    sync_in[b] = 1'b0;
    @(negedge clk);
    sync_in[b] = 1'b1;
    repeat (2) @(negedge clk);
  endtask
  always @(posedge clk) begin
    cycles++;
    evt1 += evt_out[1];
    evt2 += evt_out[2];
    srv1 += req_out[1] & ack[1];
    srv3 += req_out[3] & ack[3];
    evt3 += evt_out[3];
    if (cycles == 3000) begin
      fail_count++;
      conclude();
    end
  end
  initial begin
    repeat (2) @(negedge clk);
    rst = 1'b0;
    rd_reg(12'h02c);
    chk(got, 32'h0);
    foreach (rows[i]) begin
      req_in = '0;
      req_in[rows[i].line] = 1'b1;
      wr_reg(12'h000, {25'h0, rows[i].sel});
      chk({31'h0, req_out[0]}, {31'h0, rows[i].out});
    end
    wr_reg(12'h000, 32'hffffffff);
    rd_reg(12'h000);
    chk(got, 32'h1fff037f);
    rd_reg(12'h030);
    chk(got, 32'h0);
    req_in = '0;
    req_in[50] = 1'b1;
    req_in[39] = 1'b1;
    wr_reg(12'h004, 32'h160b0332);
    chk({31'h0, req_out[1]}, 32'h0);
    pulse_sync(22);
    repeat (8) @(negedge clk);
    chk(32'(srv1), 32'h2);
    chk(32'(evt1), 32'h1);
    chk({31'h0, req_out[1]}, 32'h0);
    stall = 1'b1;
    pulse_sync(22);
    pulse_sync(22);
    rd_reg(rr_pkg::FLAGS_ADDR);
    chk(got, 32'h2);
    chk({31'h0, irq}, 32'h1);
    wr_reg(rr_pkg::CLEARS_ADDR, 32'h0);
    rd_reg(rr_pkg::FLAGS_ADDR);
    chk(got, 32'h2);
    wr_reg(rr_pkg::CLEARS_ADDR, 32'h2);
    rd_reg(rr_pkg::FLAGS_ADDR);
    chk(got, 32'h0);
    chk({31'h0, irq}, 32'h0);
    wr_reg(12'h004, 32'h0);
    wr_reg(12'h004, 32'h160b0232);
    pulse_sync(22);
    pulse_sync(22);
    rd_reg(rr_pkg::FLAGS_ADDR);
    chk(got, 32'h2);
    chk({31'h0, irq}, 32'h0);
    stall = 1'b0;
    foreach (ps[i]) begin
      wr_reg(12'h008, 32'h0);
      wr_reg(12'h008, {3'h0, ps[i].ss, 5'h0, ps[i].pol, 1'b1, 6'h0,
        1'b1, 9'h027});
      evt2 = 0;
      sync_in[ps[i].ss] = 1'b1;
      repeat (6) @(negedge clk);
      sync_in[ps[i].ss] = 1'b0;
      repeat (6) @(negedge clk);
      chk(32'(evt2), 32'(ps[i].n));
    end
    // free-running count with events but no sync gate
    req_in[40] = 1'b1;
    wr_reg(12'h00c, 32'h0008_0228);
    repeat (20) @(negedge clk);
    wr_reg(12'h00c, 32'h0);
    chk(32'(evt3), 32'(srv3 / 2));
    chk({31'h0, srv3 >= 4}, 32'h1);
    rd_reg(rr_pkg::CLEARS_ADDR);
    chk(got, 32'h0);
    // mid-run reset must drop config and the pending overrun flag
    rst = 1'b1;
    repeat (2) @(negedge clk);
    rst = 1'b0;
    rd_reg(12'h004);
    chk(got, 32'h0);
    rd_reg(rr_pkg::FLAGS_ADDR);
    chk(got, 32'h0);
    chk({20'h0, req_out | evt_out}, 32'h0);
    conclude();
  end
endmodule // testbench
